/* i2c_slave_pkg.sv */
// Constants and carrier type of the two-wire slave front end.
// Assumes a register core that answers reads one mclk after the strobe.
package i2c_slave_pkg;
   // ----------------------------------------
   // Bus constants
   // ----------------------------------------
   localparam logic [6:0] SLAVE_ADDR = 7'h68;
   localparam int BYTE_WIDTH = 8;
   localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
   localparam logic [3:0] BIT_CNT_LAST = 4'h7;
   localparam logic [3:0] BIT_CNT_ONE = 4'h1;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
   localparam logic [7:0] PTR_RESET = 8'h00;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic SDA_LOW_LEVEL = 1'b0;

   // ----------------------------------------
   // Register core access carrier
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_access_type;

   localparam reg_access_type REG_ACCESS_IDLE = '0;
endpackage

/* sync_2ff.sv */
// Two-flop level synchroniser.
// Assumes inputs are levels from another clock or from pins.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;

   // ----------------------------------------
   // Synchroniser stages
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      meta_reg <= d;
      q <= meta_reg;
   end
endmodule
`default_nettype wire

/* pulse_cross.sv */
// Toggle-based single-pulse crossing between two clocks.
// Assumes source pulses are spaced by several destination cycles.
`timescale 1ns/1ps
`default_nettype none
module pulse_cross (
   input wire logic src_clk,
   input wire logic src_rst,
   input wire logic src_pulse,
   input wire logic dst_clk,
   input wire logic dst_rst,
   output logic dst_pulse
);
   logic toggle_reg;
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   // ----------------------------------------
   // Source toggle
   // ----------------------------------------
   always_ff @(posedge src_clk)
   begin
      if (src_rst)
         toggle_reg <= 1'b0;
      else if (src_pulse)
         toggle_reg <= ~toggle_reg;
   end

   // ----------------------------------------
   // Destination sync and edge
   // ----------------------------------------
   always_ff @(posedge dst_clk)
   begin
      if (dst_rst)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= toggle_reg;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign dst_pulse = sync_reg ^ prev_reg;
endmodule
`default_nettype wire

/* i2c_slave_register_access.sv */
// Two-wire slave front end with register pointer and core access.
// Assumes the bus master drives the clock line and a sampling clock.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_register_access (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic bus_sample_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output i2c_slave_pkg::reg_access_type reg_access,
   input wire logic [7:0] reg_rd_data
);
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_PTR_ACK,
      ST_WDATA,
      ST_WDATA_ACK,
      ST_RDATA,
      ST_RDATA_ACK,
      ST_IGNORE
   } state_type;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic link_rst, scl_s, sda_s, scl_prev_reg, sda_prev_reg;
   logic start_det, stop_det, scl_rise, scl_fall;
   state_type state_reg, state_next;
   logic [3:0] bit_cnt_reg;
   logic [7:0] rx_shift_reg, tx_shift_reg, ptr_reg, ptr_inc;
   logic rw_reg, sda_oe_reg, rx_state, ack_state, rx_sample, rx_end;
   logic addr_match, ack_end, tx_shift_evt, tx_end, tx_load, mack_sample;
   logic addr_end, rd_first, wr_store;
   logic [7:0] wr_addr_reg, wr_data_reg, rd_addr_reg, rd_buf_reg;
   logic wr_evt_reg, rd_evt_reg, wr_pulse_m, rd_pulse_m, rd_done_link;
   logic rd_capture_reg, rd_done_reg;
   logic [7:0] rd_hold_reg;
   i2c_slave_pkg::reg_access_type reg_access_reg;

   // ----------------------------------------
   // Reset and pin synchronisers
   // ----------------------------------------
   sync_2ff #(
      .WIDTH(1)
   ) u_rst_sync (
      .clk(bus_sample_clk),
      .d(sys_rst),
      .q(link_rst)
   );

   sync_2ff #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk(bus_sample_clk),
      .d({scl_in, sda_in}),
      .q({scl_s, sda_s})
   );

   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
      begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end
      else
      begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   // ----------------------------------------
   // Bus condition decode
   // ----------------------------------------
   assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
   assign scl_rise = scl_s & ~scl_prev_reg;
   assign scl_fall = ~scl_s & scl_prev_reg;

   assign rx_state = (state_reg == ST_ADDR) || (state_reg == ST_PTR) ||
                     (state_reg == ST_WDATA);
   assign ack_state = (state_reg == ST_ADDR_ACK) || (state_reg == ST_PTR_ACK) ||
                      (state_reg == ST_WDATA_ACK);
   assign rx_sample = scl_rise && rx_state && !start_det && !stop_det;
   assign rx_end = scl_fall && rx_state && (bit_cnt_reg == i2c_slave_pkg::BIT_CNT_BYTE);
   assign addr_match = (rx_shift_reg[7:1] == i2c_slave_pkg::SLAVE_ADDR);
   assign addr_end = rx_end && (state_reg == ST_ADDR);
   assign rd_first = addr_end && addr_match && rx_shift_reg[0];
   assign wr_store = rx_end && (state_reg == ST_WDATA);
   assign ack_end = scl_fall && ack_state;
   assign tx_shift_evt = scl_fall && (state_reg == ST_RDATA) &&
                         (bit_cnt_reg != i2c_slave_pkg::BIT_CNT_LAST);
   assign tx_end = scl_fall && (state_reg == ST_RDATA) &&
                   (bit_cnt_reg == i2c_slave_pkg::BIT_CNT_LAST);
   assign mack_sample = scl_rise && (state_reg == ST_RDATA_ACK);
   assign tx_load = (ack_end && (state_reg == ST_ADDR_ACK) && rw_reg) ||
                    (scl_fall && (state_reg == ST_RDATA_ACK));
   assign ptr_inc = ptr_reg + i2c_slave_pkg::PTR_STEP;

   // ----------------------------------------
   // Transfer state machine
   // ----------------------------------------
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
            state_next = ST_IDLE;
         ST_ADDR:
            if (rx_end)
               state_next = addr_match ? ST_ADDR_ACK : ST_IGNORE;
         ST_ADDR_ACK:
            if (scl_fall)
               state_next = rw_reg ? ST_RDATA : ST_PTR;
         ST_PTR:
            if (rx_end)
               state_next = ST_PTR_ACK;
         ST_PTR_ACK:
            if (scl_fall)
               state_next = ST_WDATA;
         ST_WDATA:
            if (rx_end)
               state_next = ST_WDATA_ACK;
         ST_WDATA_ACK:
            if (scl_fall)
               state_next = ST_WDATA;
         ST_RDATA:
            if (tx_end)
               state_next = ST_RDATA_ACK;
         ST_RDATA_ACK:
            if (mack_sample && sda_s)
               state_next = ST_IDLE;
            else if (scl_fall)
               state_next = ST_RDATA;
         ST_IGNORE:
            state_next = ST_IGNORE;
         default:
            state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
         state_reg <= ST_IDLE;
      else if (start_det)
         state_reg <= ST_ADDR;
      else if (stop_det)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // ----------------------------------------
   // Bit counter
   // ----------------------------------------
   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst || start_det)
         bit_cnt_reg <= i2c_slave_pkg::BIT_CNT_ZERO;
      else if (rx_end || tx_load)
         bit_cnt_reg <= i2c_slave_pkg::BIT_CNT_ZERO;
      else if (rx_sample || tx_shift_evt)
         bit_cnt_reg <= bit_cnt_reg + i2c_slave_pkg::BIT_CNT_ONE;
   end

   // ----------------------------------------
   // Receive shifter and direction
   // ----------------------------------------
   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
         rx_shift_reg <= i2c_slave_pkg::BYTE_ZERO;
      else if (rx_sample)
         rx_shift_reg <= {rx_shift_reg[6:0], sda_s};
   end

   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
         rw_reg <= 1'b0;
      else if (addr_end)
         rw_reg <= rx_shift_reg[0];
   end

   // ----------------------------------------
   // Register pointer
   // ----------------------------------------
   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
         ptr_reg <= i2c_slave_pkg::PTR_RESET;
      else if (rx_end && (state_reg == ST_PTR))
         ptr_reg <= rx_shift_reg;
      else if (wr_store)
         ptr_reg <= ptr_inc;
      else if (tx_end)
         ptr_reg <= ptr_inc;
   end

   // ----------------------------------------
   // Write and read requests
   // ----------------------------------------
   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
      begin
         wr_addr_reg <= i2c_slave_pkg::BYTE_ZERO;
         wr_data_reg <= i2c_slave_pkg::BYTE_ZERO;
         wr_evt_reg <= 1'b0;
      end
      else
      begin
         wr_evt_reg <= wr_store;
         if (wr_store)
         begin
            wr_addr_reg <= ptr_reg;
            wr_data_reg <= rx_shift_reg;
         end
      end
   end

   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
      begin
         rd_addr_reg <= i2c_slave_pkg::BYTE_ZERO;
         rd_evt_reg <= 1'b0;
      end
      else
      begin
         rd_evt_reg <= rd_first || tx_end;
         if (rd_first)
            rd_addr_reg <= ptr_reg;
         else if (tx_end)
            rd_addr_reg <= ptr_inc;
      end
   end

   // ----------------------------------------
   // Transmit buffer and shifter
   // ----------------------------------------
   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
         rd_buf_reg <= i2c_slave_pkg::BYTE_ZERO;
      else if (rd_done_link)
         rd_buf_reg <= rd_hold_reg;
   end

   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst)
         tx_shift_reg <= i2c_slave_pkg::BYTE_ZERO;
      else if (tx_load)
         tx_shift_reg <= rd_buf_reg;
      else if (tx_shift_evt)
         tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
   end

   // ----------------------------------------
   // Data line drive
   // ----------------------------------------
   always_ff @(posedge bus_sample_clk)
   begin
      if (link_rst || start_det || stop_det)
         sda_oe_reg <= 1'b0;
      else if (rx_end)
         sda_oe_reg <= (state_reg != ST_ADDR) || addr_match;
      else if (tx_load)
         sda_oe_reg <= ~rd_buf_reg[7];
      else if (ack_end)
         sda_oe_reg <= 1'b0;
      else if (tx_shift_evt)
         sda_oe_reg <= ~tx_shift_reg[6];
      else if (tx_end)
         sda_oe_reg <= 1'b0;
   end

   assign sda_oe = sda_oe_reg;
   assign sda_out = i2c_slave_pkg::SDA_LOW_LEVEL;

   // ----------------------------------------
   // Clock domain crossings
   // ----------------------------------------
   pulse_cross u_wr_cross (
      .src_clk(bus_sample_clk),
      .src_rst(link_rst),
      .src_pulse(wr_evt_reg),
      .dst_clk(mclk),
      .dst_rst(sys_rst),
      .dst_pulse(wr_pulse_m)
   );

   pulse_cross u_rd_cross (
      .src_clk(bus_sample_clk),
      .src_rst(link_rst),
      .src_pulse(rd_evt_reg),
      .dst_clk(mclk),
      .dst_rst(sys_rst),
      .dst_pulse(rd_pulse_m)
   );

   pulse_cross u_rd_done_cross (
      .src_clk(mclk),
      .src_rst(sys_rst),
      .src_pulse(rd_done_reg),
      .dst_clk(bus_sample_clk),
      .dst_rst(link_rst),
      .dst_pulse(rd_done_link)
   );

   // ----------------------------------------
   // Register core access
   // ----------------------------------------
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         reg_access_reg <= i2c_slave_pkg::REG_ACCESS_IDLE;
      else
      begin
         reg_access_reg.wr <= wr_pulse_m;
         reg_access_reg.rd <= rd_pulse_m && !wr_pulse_m;
         if (wr_pulse_m)
         begin
            reg_access_reg.addr <= wr_addr_reg;
            reg_access_reg.data <= wr_data_reg;
         end
         else if (rd_pulse_m)
            reg_access_reg.addr <= rd_addr_reg;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         rd_capture_reg <= 1'b0;
         rd_done_reg <= 1'b0;
         rd_hold_reg <= i2c_slave_pkg::BYTE_ZERO;
      end
      else
      begin
         rd_capture_reg <= reg_access_reg.rd;
         rd_done_reg <= rd_capture_reg;
         if (rd_capture_reg)
            rd_hold_reg <= reg_rd_data;
      end
   end

   assign reg_access = reg_access_reg;
endmodule
`default_nettype wire

/* i2c_slave_chk.sv */
// Concurrent checks on the two-wire slave front end.
// Bound to the slave top module by the testbench.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_chk (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic bus_sample_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire i2c_slave_pkg::reg_access_type reg_access,
   input wire logic [7:0] reg_rd_data
);
   wr_rd_excl_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !(reg_access.wr && reg_access.rd)) else $error("wr and rd together");
   req_spacing_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_access.wr || reg_access.rd) |=> !(reg_access.wr || reg_access.rd) [*8])
      else $error("core requests too close");
   addr_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !reg_access.wr && !reg_access.rd && !$past(sys_rst) |-> $stable(reg_access.addr))
      else $error("address moved without request");
   data_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !reg_access.wr && !reg_access.rd && !$past(sys_rst) |-> $stable(reg_access.data))
      else $error("data moved without request");
   open_drain_a: assert property (@(posedge mclk) disable iff (sys_rst)
      sda_out == 1'b0) else $error("data line driven high");
   oe_scl_low_a: assert property (@(posedge bus_sample_clk) disable iff (sys_rst)
      $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
      else $error("data line changed while clock high");
   reset_idle_a: assert property (@(posedge mclk)
      sys_rst |=> reg_access == i2c_slave_pkg::REG_ACCESS_IDLE)
      else $error("core access not idle in reset");
   oe_reset_a: assert property (@(posedge bus_sample_clk)
      sys_rst [*5] |-> !sda_oe) else $error("data line held in reset");
endmodule
`default_nettype wire

/* i2c_bus_master.sv */
// Bus master model driving the clock line and its share of the data line.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_master (
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   localparam int Q = 1000;
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic send_bit(input logic b);
      #Q sda_low = !b;
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
   endtask
   task automatic recv_bit(output logic b);
      #Q sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q b = sda;
      #Q scl = 1'b0;
   endtask
   task automatic start;
      sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic stop;
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask
   task automatic write_byte(input logic [7:0] d, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
         send_bit(d[i]);
      recv_bit(a);
      ack = !a;
   endtask
   task automatic read_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         recv_bit(d[i]);
      send_bit(last);
   endtask
endmodule
`default_nettype wire

/* tb_i2c_slave_register_access.sv */
// Self-checking bench for the two-wire slave front end.
// Assumes the master model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_slave_register_access;
   logic mclk = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic scl;
   logic m_low;
   logic sda;
   logic sda_out;
   logic sda_oe;
   i2c_slave_pkg::reg_access_type reg_access;
   logic [7:0] reg_rd_data;
   logic [7:0] mem [256];
   int wr_cnt = 0;
   int mismatches = 0;
   int compares = 0;
   initial forever #50 mclk = !mclk;
   initial
   begin
      #13;
      forever #40 link_clk = !link_clk;
   end
   assign sda = !((sda_oe === 1'b1) && (sda_out === 1'b0)) && !m_low;
   assign reg_rd_data = mem[reg_access.addr];
   i2c_slave_register_access dut_u (
      .mclk(mclk), .sys_rst(sys_rst), .bus_sample_clk(link_clk), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .reg_access(reg_access),
      .reg_rd_data(reg_rd_data)
   );
   i2c_bus_master master_u (.sda(sda), .scl(scl), .sda_low(m_low));
   always @(posedge mclk)
      if (reg_access.wr === 1'b1)
      begin
         mem[reg_access.addr] <= reg_access.data;
         wr_cnt <= wr_cnt + 1;
      end
   function automatic logic [7:0] pat(input logic [7:0] a);
      return a ^ 8'h5A;
   endfunction
   task automatic check(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1)
      begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic put(input logic [7:0] d, input logic exp_ack);
      logic a;
      master_u.write_byte(d, a);
      check(a === exp_ack, "acknowledge");
   endtask
   task automatic get(input logic last, input logic [7:0] exp);
      logic [7:0] d;
      master_u.read_byte(last, d);
      check(d === exp, "read data");
   endtask
   task automatic do_reset(input int hold);
      @(negedge mclk) sys_rst = 1'b1;
      repeat (hold) @(negedge mclk);
      check(reg_access === i2c_slave_pkg::REG_ACCESS_IDLE, "reset access");
      check(sda_oe === 1'b0 && sda_out === 1'b0, "reset line");
      sys_rst = 1'b0;
      repeat (10) @(negedge mclk);
   endtask
   task automatic t_write;
      master_u.start();
      put(8'hD0, 1'b1);
      put(8'hFE, 1'b1);
      for (int i = 0; i < 3; i++)
         put(8'hA1 + 8'(i * 17), 1'b1);
      master_u.stop();
      check(mem[8'hFE] === 8'hA1 && mem[8'hFF] === 8'hB2, "store");
      check(mem[8'h00] === 8'hC3 && wr_cnt == 3, "store wrap");
   endtask
   task automatic t_read_cur;
      master_u.start();
      put(8'hD1, 1'b1);
      get(1'b0, pat(8'h01));
      get(1'b1, pat(8'h02));
      #1000;
      check(sda === 1'b1, "line released after nack");
      master_u.stop();
   endtask
   task automatic t_zero;
      int w;
      w = wr_cnt;
      master_u.start();
      put(8'hD0, 1'b1);
      put(8'h30, 1'b1);
      master_u.stop();
      master_u.start();
      put(8'hD1, 1'b1);
      get(1'b1, pat(8'h30));
      master_u.stop();
      check(wr_cnt == w, "no store");
   endtask
   task automatic t_restart;
      int w;
      w = wr_cnt;
      master_u.start();
      put(8'hD0, 1'b1);
      put(8'h40, 1'b1);
      for (int i = 0; i < 4; i++)
         master_u.send_bit(i[0]);
      master_u.start();
      put(8'hD1, 1'b1);
      get(1'b1, pat(8'h40));
      master_u.stop();
      check(wr_cnt == w, "aborted byte stored");
   endtask
   task automatic t_miss;
      int w;
      logic [7:0] adr [2] = '{8'hD2, 8'h50};
      w = wr_cnt;
      foreach (adr[i])
      begin
         master_u.start();
         put(adr[i], 1'b0);
         put(8'h00, 1'b0);
         master_u.stop();
      end
      check(wr_cnt == w, "store on foreign address");
   endtask
   task automatic t_midreset;
      do_reset(5);
      master_u.start();
      put(8'hD1, 1'b1);
      get(1'b1, 8'hC3);
      master_u.stop();
   endtask
   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      $display("unexpected at %0t: run too long", $time);
      end_sim();
   end
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = pat(8'(i));
      do_reset(2);
      t_write();
      t_read_cur();
      t_zero();
      t_restart();
      t_miss();
      t_midreset();
      end_sim();
   end
endmodule
bind i2c_slave_register_access i2c_slave_chk chk_u (
   .mclk(mclk), .sys_rst(sys_rst), .bus_sample_clk(bus_sample_clk), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .reg_access(reg_access),
   .reg_rd_data(reg_rd_data)
);
`default_nettype wire
